// ==== verilog/fill_pkg.sv ====
// package: constants, register map and carrier types for the prefetch-read fifo
`default_nettype none
package fill_pkg;
   // documented sizes
   localparam int DEPTH_DEF      = 16;   // array depth, power of two
   localparam int DATA_W_DEF     = 8;    // stored word width
   localparam int PREFETCH_WORDS = 2;    // extra words held in the read stages

   // counter values when the fifo is empty, symmetric ports
   localparam int ACC_EMPTY_WR     = 2;  // accurate write-side count
   localparam int ACC_EMPTY_COMMON = 2;  // accurate common count
   localparam int APPROX_EMPTY_WR  = 0;  // approximate write-side count
   localparam int RD_EMPTY         = 0;  // read-side count, either style

   // update latency in extra cycles beyond the output register
   localparam int PORT_COUNT_LAG   = 1;  // write-side and read-side counts
   localparam int COMMON_COUNT_LAG = 0;  // common count, same edge

   // register byte offsets on the bus
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h04;
   localparam logic [7:0] REG_WR_COUNT = 8'h08;
   localparam logic [7:0] REG_RD_COUNT = 8'h0C;
   localparam logic [7:0] REG_COUNT    = 8'h10;

   // control register layout and reset value
   localparam int          CTRL_FLUSH_BIT = 0;
   localparam logic        CTRL_RESET     = 1'b0;

   // ahb transfer type bit that marks an active transfer
   localparam int          HTRANS_ACTIVE_BIT = 1;

   // status flags as they travel together and appear in REG_STATUS
   typedef struct packed {
      logic common;         // common count valid
      logic accurate;       // accurate counting style built
      logic almost_empty;   // at most one word in the read stages
      logic empty;          // no word at the read port
      logic full;           // array cannot take a write
   } status_t;
endpackage
`default_nettype wire

// ==== verilog/fifo_store.sv ====
// fifo_store: dual-pointer word array that holds depth-1 words like a standard fifo
`default_nettype none
module fifo_store #(
   parameter int DEPTH  = 16,
   parameter int DATA_W = 8,
   parameter int CW     = 5
) (
   // clock and clear
   input  wire logic              mclk,
   input  wire logic              clr,
   // write side
   input  wire logic              push,
   input  wire logic [DATA_W-1:0] push_data,
   // read side
   input  wire logic              pop,
   output logic      [DATA_W-1:0] head,
   // occupancy
   output logic      [CW-1:0]     count,
   output logic                   full
);
   import fill_pkg::*;

   localparam int AW = $clog2(DEPTH);

   logic [DATA_W-1:0] mem [0:DEPTH-1];  // word storage
   logic [AW-1:0]     wr_ptr;           // next slot to write
   logic [AW-1:0]     rd_ptr;           // oldest word

   // one slot stays empty so pointers never alias
   assign full = (count == CW'(DEPTH - 1));
   // head is read without a register so a pop can refill the stages in one edge
   assign head = mem[rd_ptr];

   // storage write, no reset needed on data
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr] <= push_data;
      end
   end

   // pointers and count
   always_ff @(posedge mclk) begin
      if (clr) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         count <= count + CW'(push) - CW'(pop);
      end
   end
endmodule
`default_nettype wire

// ==== verilog/count_view.sv ====
// count_view: saturating output register for one fill count with a fixed lag
`default_nettype none
module count_view #(
   parameter int CW  = 5,
   parameter int LAG = 1
) (
   // clock and clear
   input  wire logic          mclk,
   input  wire logic          clr,
   // count source
   input  wire logic [CW-1:0] sat_max,
   input  wire logic [CW:0]   raw_next,
   // shown count
   output logic      [CW-1:0] count
);
   import fill_pkg::*;

   logic [CW-1:0] pipe [0:LAG];   // stage 0 loads on the edge of the change
   logic [CW-1:0] clipped;        // raw value limited to the output range

   // clip rather than wrap so a narrow count never shows a small value when high
   assign clipped = (raw_next > {1'b0, sat_max}) ? sat_max : raw_next[CW-1:0];
   assign count   = pipe[LAG];

   // lag pipeline, cleared while the fifo is held
   always_ff @(posedge mclk) begin
      if (clr) begin
         for (int i = 0; i <= LAG; i++) begin
            pipe[i] <= '0;
         end
      end else begin
         pipe[0] <= clipped;
         for (int i = 1; i <= LAG; i++) begin
            pipe[i] <= pipe[i-1];
         end
      end
   end
endmodule
`default_nettype wire

// ==== verilog/prefetch_read_mode_fill_counts.sv ====
// prefetch_read_mode_fill_counts: prefetch-read fifo with write, read and common fill counts
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`default_nettype none
// Operation
// - prefetch stages add two readable words
// - build-time choice: approximate or accurate counts
// - approximate default; never with common clock
// - approximate widths equal log2 of depths
// - depth 16 holds 17, counts 4 bits
// - accurate widths one bit wider
// - common count exact except near empty
// - common count exact from write side
// - common over-reports by up to two until settled
// - accurate write count stays pessimistic
// - write count over-reports until stages filled
// - reset forces write and common counts zero
// - empty write count: approximate 0, accurate 2
// - empty accurate common count reads 2
// - empty read count reads zero
// - writes gated by full, reads by empty
// - port counts show one cycle later
// - read under-reports, write over-reports
// - common count updates on same edge
module prefetch_read_mode_fill_counts #(
   parameter int   DEPTH        = fill_pkg::DEPTH_DEF,
   parameter int   DATA_W       = fill_pkg::DATA_W_DEF,
   parameter logic ACCURATE     = 1'b0,
   parameter logic COMMON_CLOCK = 1'b0
) (
   // clock and reset
   input  wire logic                          mclk,
   input  wire logic                          sys_rst,
   // user write port
   input  wire logic                          wr_req,
   input  wire logic [DATA_W-1:0]             wr_data,
   // user read port
   input  wire logic                          rd_req,
   output logic      [DATA_W-1:0]             rd_data,
   // flags
   output fill_pkg::status_t                  status,
   // fill counts
   output logic      [$clog2(DEPTH):0]        wr_count,
   output logic      [$clog2(DEPTH):0]        rd_count,
   output logic      [$clog2(DEPTH):0]        common_count,
   // ahb-lite slave
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic                               hresp,
   output logic      [31:0]                   hrdata
);
   import fill_pkg::*;

   localparam int LW = $clog2(DEPTH);   // approximate width
   localparam int CW = LW + 1;          // port width, accurate width
   localparam logic USE_ACC = ACCURATE | COMMON_CLOCK;
   localparam logic [CW-1:0] APPROX_MAX = CW'((1 << LW) - 1);
   localparam logic [CW-1:0] ACC_MAX = CW'((1 << CW) - 1);

   // prefetch stages
   logic [DATA_W-1:0] stage0;        // word shown at the read port
   logic [DATA_W-1:0] stage1;        // next word behind it
   logic [1:0]        occ;           // words held in the stages
   logic [1:0]        occ_after;     // stages left after this cycle's read
   logic [1:0]        next_occ;
   logic              refill;        // move one word from array to stages
   // array side
   logic [DATA_W-1:0] head;
   logic [CW-1:0]     store_count;   // words in the array
   logic              full;
   logic [CW:0]       next_store;
   logic [CW:0]       next_total;
   logic [CW:0]       total;         // all words held
   // accepted transfers
   logic              acc_wr;
   logic              acc_rd;
   logic              empty;
   // count sources
   logic [CW:0]       raw_wr;
   logic [CW:0]       raw_common;
   // control
   logic              ctrl_flush;    // software hold of the fifo
   logic              hold;          // reset or software hold
   // bus
   logic              bus_wr_pend;
   logic [7:0]        bus_wr_addr;
   logic              addr_take;

   assign hold = sys_rst | ctrl_flush;

   assign acc_wr = wr_req & ~full & ~hold;
   // read only when a word is shown
   assign acc_rd = rd_req & ~empty & ~hold;

   assign empty     = (occ == 2'd0);
   assign occ_after = occ - 2'(acc_rd);
   // keep both prefetch stages topped up
   assign refill    = (occ_after < 2'(PREFETCH_WORDS)) && (store_count != '0) && !hold;
   assign next_occ  = occ_after + 2'(refill);
   assign next_store = (CW+1)'(store_count) + (CW+1)'(acc_wr) - (CW+1)'(refill);
   assign next_total = next_store + (CW+1)'(next_occ);
   assign total      = (CW+1)'(store_count) + (CW+1)'(occ);
   assign rd_data    = stage0;

   // standard-mode array that the stages drain
   fifo_store #(
      .DEPTH  (DEPTH),
      .DATA_W (DATA_W),
      .CW     (CW)
   ) u_store (
      .mclk      (mclk),
      .clr       (hold),
      .push      (acc_wr),
      .push_data (wr_data),
      .pop       (refill),
      .head      (head),
      .count     (store_count),
      .full      (full)
   );

   // occupancy of the prefetch stages
   always_ff @(posedge mclk) begin
      if (hold) begin
         occ <= 2'd0;
      end else begin
         occ <= next_occ;
      end
   end

   // stage data: shift on read, then append the array head behind what is left
   always_ff @(posedge mclk) begin
      if (acc_rd && occ == 2'd2) begin
         stage0 <= stage1;
      end
      if (refill) begin
         if (occ_after == 2'd0) begin
            stage0 <= head;
         end else begin
            stage1 <= head;
         end
      end
   end

   // accurate write count assumes both stages occupied, never under
   // over-reports by up to two until the stages fill
   // accurate empty shows two, approximate empty shows zero
   always_comb begin
      if (USE_ACC) begin
         raw_wr = next_store + (CW+1)'(ACC_EMPTY_WR);
      end else begin
         raw_wr = next_total + (CW+1)'(APPROX_EMPTY_WR);
      end
   end

   // common count exact once the stages hold both words
   // over-reports by at most the two stage words
   always_comb begin
      if (USE_ACC && COMMON_CLOCK) begin
         raw_common = next_store + (CW+1)'(ACC_EMPTY_COMMON);
      end else begin
         raw_common = '0;
      end
   end

   // write-side count one cycle behind the write
   count_view #(
      .CW  (CW),
      .LAG (PORT_COUNT_LAG)
   ) u_wr_view (
      .mclk     (mclk),
      .clr      (hold),
      .sat_max  (USE_ACC ? ACC_MAX : APPROX_MAX),
      .raw_next (raw_wr),
      .count    (wr_count)
   );

   // read count of an empty fifo is zero
   // read count lags writes, never runs ahead of them
   count_view #(
      .CW  (CW),
      .LAG (PORT_COUNT_LAG)
   ) u_rd_view (
      .mclk     (mclk),
      .clr      (hold),
      .sat_max  (USE_ACC ? ACC_MAX : APPROX_MAX),
      .raw_next (next_total + (CW+1)'(RD_EMPTY)),
      .count    (rd_count)
   );

   // common count loads on the edge of the transfer
   // write shows at once from the write side
   count_view #(
      .CW  (CW),
      .LAG (COMMON_COUNT_LAG)
   ) u_common_view (
      .mclk     (mclk),
      .clr      (hold),
      .sat_max  (ACC_MAX),
      .raw_next (raw_common),
      .count    (common_count)
   );

   // flags, combinational from state so they track each edge
   always_comb begin
      status.full         = full | hold;
      status.empty        = empty;
      status.almost_empty = (occ < 2'd2);
      status.accurate     = USE_ACC;
      status.common       = COMMON_CLOCK;
   end

   // bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_take = hsel & hready & htrans[HTRANS_ACTIVE_BIT];

   // remember a write address phase; data lands in the next cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         bus_wr_pend <= 1'b0;
         bus_wr_addr <= 8'h00;
      end else begin
         bus_wr_pend <= addr_take & hwrite;
         bus_wr_addr <= haddr[7:0];
      end
   end

   // control register; only the flush bit is writable
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_flush <= CTRL_RESET;
      end else if (bus_wr_pend && bus_wr_addr == REG_CTRL) begin
         ctrl_flush <= hwdata[CTRL_FLUSH_BIT];
      end
   end

   // read data sampled at the address phase, shown during the data phase;
   // the upper address bits are not decoded, so the map repeats every 256 bytes
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_take && !hwrite) begin
         if (haddr[7:0] == REG_CTRL) begin
            hrdata <= {31'h0000_0000, ctrl_flush};
         end else if (haddr[7:0] == REG_STATUS) begin
            hrdata <= {27'h000_0000, status};
         end else if (haddr[7:0] == REG_WR_COUNT) begin
            hrdata <= 32'(wr_count);
         end else if (haddr[7:0] == REG_RD_COUNT) begin
            hrdata <= 32'(rd_count);
         end else if (haddr[7:0] == REG_COUNT) begin
            hrdata <= 32'(common_count);
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // checks on the fill logic
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_settled;
      !hold && !$past(hold) && !$past(hold, 2);
   endsequence

   sequence s_first_word;
      (acc_wr && total == '0 && !hold) ##1 !hold ##1 !hold;
   endsequence

   a_hold_zeroes: assert property (@(posedge mclk) disable iff (1'b0)
      $past(hold) |-> (wr_count == '0 && common_count == '0 && rd_count == '0))
      else $error("counts not zero after hold");

   a_full_refused: assert property (wr_req && full |=>
      store_count <= $past(store_count))
      else $error("write taken while full");

   a_total_track: assert property (!hold ##1 !hold |->
      total == $past(total) + (CW+1)'($past(acc_wr)) - (CW+1)'($past(acc_rd)))
      else $error("word total does not follow accepted transfers");

   a_prefetch_depth: assert property (total <= (CW+1)'(DEPTH + 1))
      else $error("more words held than prefetch depth allows");

   a_fall_through: assert property (s_first_word |-> !empty)
      else $error("first word not shown two edges after write");

   a_wr_lag: assert property ((s_settled and USE_ACC) |->
      wr_count == CW'($past(store_count)) + CW'(ACC_EMPTY_WR))
      else $error("accurate write count wrong or wrong lag");

   a_common_edge: assert property ((s_settled and COMMON_CLOCK) |->
      common_count == store_count + CW'(ACC_EMPTY_COMMON))
      else $error("common count not updated on the transfer edge");

   a_rd_lag: assert property (s_settled |->
      rd_count == (($past(total) > (CW+1)'(USE_ACC ? ACC_MAX : APPROX_MAX)) ?
                   (USE_ACC ? ACC_MAX : APPROX_MAX) : CW'($past(total))))
      else $error("read count wrong or wrong lag");

   a_wr_pessimist: assert property ((s_settled and USE_ACC) |->
      (CW+1)'(wr_count) + (CW+1)'(1) >= total)
      else $error("write count under-reports beyond one cycle of lag");

   a_approx_clip: assert property (!USE_ACC |-> wr_count[LW] == 1'b0)
      else $error("approximate write count exceeds its width");
endmodule
`default_nettype wire

// ==== dv/rd_user_model.sv ====
// rd_user_model: read-side user logic that pulls words at full or half rate
`default_nettype none
module rd_user_model (
   // clock
   input  wire logic mclk,
   // control from the bench
   input  wire logic go,
   input  wire logic slow,
   // fifo read port
   output logic      rd_req
);
   timeunit 1ns;
   timeprecision 1ps;

   logic tog = 1'b0;   // alternates every cycle to stall the reader in slow mode

   // request after the edge, held for the whole cycle.
   // empty is not looked at on purpose, so reads at empty are offered and must be refused.
   // counts never used
   // no single count bit as level
   // the reader paces itself and never trusts the write-side count near empty
   always @(posedge mclk) begin
      tog    <= ~tog;
      rd_req <= go && (!slow || tog);
   end
endmodule
`default_nettype wire

// ==== dv/prefetch_read_mode_fill_counts_tb.sv ====
// prefetch_read_mode_fill_counts_tb: self-checking bench for the prefetch-read fifo fill counts
`default_nettype none
module prefetch_read_mode_fill_counts_tb;
   import fill_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic              mclk      = 1'b0;   // 250 MHz system clock
   logic              sys_rst   = 1'b1;   // synchronous reset
   logic              wr_req    = 1'b0;   // write request
   logic [7:0]        wr_data   = 8'h00;  // write word
   logic              rd_req;             // read request from the reader model
   logic [7:0]        rd_data;            // head word
   status_t           status;             // flags
   logic [4:0]        wr_count;           // write-side count
   logic [4:0]        rd_count;           // read-side count
   logic [4:0]        common_count;       // common count
   logic              hsel      = 1'b0;   // bus select
   logic [31:0]       haddr     = 32'h0;  // bus address
   logic [1:0]        htrans    = 2'h0;   // transfer type
   logic              hwrite    = 1'b0;   // bus direction
   logic [2:0]        hsize     = 3'h0;   // transfer size
   logic [31:0]       hwdata    = 32'h0;  // bus write data
   logic              hready;             // bus ready, fed back from the one slave
   logic              hreadyout;          // slave ready
   logic              hresp;              // slave response
   logic [31:0]       hrdata;             // bus read data
   logic              go        = 1'b0;   // reader enable
   logic              slow      = 1'b0;   // reader stalls every other cycle
   int                error_cnt   = 0;    // mismatches
   int                check_count = 0;    // comparisons
   int                cycles      = 0;    // timeout counter
   logic [7:0]        data_q[$];          // words expected at the read port, oldest first
   logic [31:0]       rv;                 // last bus read value
   status_t           apx_status;         // flags, approximate build
   logic [4:0]        apx_wr_count;       // write-side count, approximate build
   logic [4:0]        apx_rd_count;       // read-side count, approximate build
   logic [4:0]        apx_common;         // common count, approximate build
   localparam int APX_TOP = (1 << $clog2(DEPTH_DEF)) - 1;  // top of an approximate count

   assign hready = hreadyout;

   always #2 mclk = ~mclk;

   prefetch_read_mode_fill_counts #(.DEPTH(DEPTH_DEF), .DATA_W(DATA_W_DEF), .ACCURATE(1'b1),
                      .COMMON_CLOCK(1'b1)) dut (
      .mclk(mclk), .sys_rst(sys_rst), .wr_req(wr_req), .wr_data(wr_data),
      .rd_req(rd_req), .rd_data(rd_data), .status(status), .wr_count(wr_count),
      .rd_count(rd_count), .common_count(common_count), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

   // second build in approximate style; same stimulus, shared bus so a flush reaches both
   prefetch_read_mode_fill_counts #(.DEPTH(DEPTH_DEF), .DATA_W(DATA_W_DEF), .ACCURATE(1'b0),
                      .COMMON_CLOCK(1'b0)) dut_apx (
      .mclk(mclk), .sys_rst(sys_rst), .wr_req(wr_req), .wr_data(wr_data),
      .rd_req(rd_req), .rd_data(), .status(apx_status), .wr_count(apx_wr_count),
      .rd_count(apx_rd_count), .common_count(apx_common), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(), .hresp(), .hrdata());

   rd_user_model reader (.mclk(mclk), .go(go), .slow(slow), .rd_req(rd_req));

   // verdict in one place, reached by the main sequence and by the timeout
   task automatic close_out();
      if (error_cnt == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // one comparison, four-state exact
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // all three counts at once
   task automatic cnt_chk(input int w, input int r, input int c);
      chk(32'(wr_count), 32'(w));      // write side
      chk(32'(rd_count), 32'(r));      // read side
      chk(32'(common_count), 32'(c));  // common
      chk(32'(apx_wr_count), 32'((r > APX_TOP) ? APX_TOP : r));
      chk(32'(apx_rd_count), 32'((r > APX_TOP) ? APX_TOP : r));
      chk(32'(apx_common), 32'h0);     // no common count
   endtask

   // single ahb-lite transfer; waits on hready, data taken at the data-phase edge
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
      chk(32'(hresp), 32'h0);
   endtask

   task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0, rv);
      chk(rv, exp);
   endtask

   // write n random words back to back; a word counts only if full was low at its edge
   task automatic wr_burst(input int n);
      logic [7:0] d;
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         wr_req  <= 1'b1;
         wr_data <= d;
         @(posedge mclk);
         if (status.full === 1'b0) data_q.push_back(d);
      end
      wr_req <= 1'b0;
   endtask

   // read monitor: every accepted read must hand out the oldest noted word
   always @(posedge mclk) begin
      if (!sys_rst && rd_req && status.empty === 1'b0) begin
         if (data_q.size() == 0)
            chk(32'(rd_data), 32'hFFFF_FFFF);
         else
            chk(32'(rd_data), 32'(data_q.pop_front()));
      end
   end

   // hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         close_out();
      end
   end

   initial begin
      void'($urandom(32'h6c19));
      repeat (2) @(posedge mclk);
      #1;
      cnt_chk(0, 0, 0);
      chk(32'(status.full), 32'h1);
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge mclk);
      cnt_chk(2, 0, 2);
      chk(32'(status.empty), 32'h1);
      // reads offered at empty must change nothing
      go <= 1'b1;
      repeat (4) @(posedge mclk);
      go <= 1'b0;
      repeat (3) @(posedge mclk);
      cnt_chk(2, 0, 2);
      wr_burst(5);
      repeat (6) @(posedge mclk);
      cnt_chk(5, 5, 5);
      // one write: common count same edge, write count one cycle later
      wr_req  <= 1'b1;
      wr_data <= 8'h5A;
      @(posedge mclk);
      data_q.push_back(8'h5A);
      wr_req <= 1'b0;
      #1;
      chk(32'(common_count), 32'h6);
      chk(32'(wr_count), 32'h5);
      @(posedge mclk);
      #1;
      chk(32'(wr_count), 32'h6);
      // fill past full: 17 words held, the rest dropped
      wr_burst(16);
      repeat (6) @(posedge mclk);
      cnt_chk(17, 17, 17);
      chk(32'(data_q.size()), 32'h11);
      // register view while full: common, accurate, not almost empty, not empty, full
      reg_chk(REG_STATUS, 32'h19);
      chk(32'(apx_status), 32'h01);
      reg_chk(REG_WR_COUNT, 32'h11);
      reg_chk(REG_RD_COUNT, 32'h11);
      reg_chk(REG_COUNT, 32'h11);
      reg_chk(8'h20, 32'h0);
      ahb(1'b1, REG_WR_COUNT, 32'h3, rv);
      reg_chk(REG_WR_COUNT, 32'h11);
      reg_chk(REG_CTRL, 32'h0);
      // drain with a stalling reader
      slow <= 1'b1;
      go   <= 1'b1;
      for (int i = 0; i < 300 && !(data_q.size() == 0 && status.empty === 1'b1); i++)
         @(posedge mclk);
      go <= 1'b0;
      repeat (6) @(posedge mclk);
      chk(32'(data_q.size()), 32'h0);
      cnt_chk(2, 0, 2);
      // writes while a fast reader keeps pace
      slow <= 1'b0;
      go   <= 1'b1;
      wr_burst(8);
      for (int i = 0; i < 100 && data_q.size() != 0; i++)
         @(posedge mclk);
      go <= 1'b0;
      repeat (6) @(posedge mclk);
      cnt_chk(2, 0, 2);
      // flush through the control register clears fifo and counts
      wr_burst(3);
      ahb(1'b1, REG_CTRL, 32'h1, rv);
      reg_chk(REG_CTRL, 32'h1);
      cnt_chk(0, 0, 0);
      ahb(1'b1, REG_CTRL, 32'h0, rv);
      data_q.delete();
      repeat (6) @(posedge mclk);
      cnt_chk(2, 0, 2);
      close_out();
   end
endmodule
`default_nettype wire
